/* logic/baud_tick_gen.sv */
// Oversample tick divider: one-cycle pulse every div clock cycles
`timescale 1ns/1ps
`default_nettype none
module baud_tick_gen
    import rx_recovery_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [DIV_W-1:0] div,
    output logic tick
);

    div_state_t st_ff;
    div_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        // Zero divisor stops the tick
        if (div == '0) begin
            nxt_st.count = '0;
        end else if (st_ff.count >= 16'(div - 1'b1)) begin
            nxt_st.count = '0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.count = st_ff.count + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;

endmodule // baud_tick_gen
`default_nettype wire

/* logic/rx_recovery.sv */
// Serial receiver data recovery with APB registers and interrupt
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rx_recovery
    import rx_recovery_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic RXD,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ
);

    rx_state_t st_ff;
    rx_state_t nxt_st;
    logic tick;

    baud_tick_gen #(
        .DIV_W(16)
    ) u_tick (
        .clk(CLK),
        .rst_n(RST_N),
        .div(st_ff.baud_div),
        .tick(tick)
    );

    logic acc_first;
    logic acc_done;
    logic rd_done;
    logic wr_done;
    logic mapped;
    logic [31:0] rd_val;
    logic s;
    logic fall;
    logic [4:0] c;
    logic [2:0] v;
    logic bit_val;
    logic unequal;
    logic frame_done;
    logic new_framing;
    logic new_noise;
    logic is_break;
    logic [3:0] last_idx;
    logic [7:0] rx_low;
    logic rx_ninth;
    logic clr_flags;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;
    logic full_irq;
    logic evt_irq;

    always_comb begin
        nxt_st = st_ff;
        // Bus decode terms
        acc_first = PSEL & PENABLE & ~st_ff.pready;
        acc_done = PSEL & PENABLE & st_ff.pready;
        rd_done = acc_done & ~PWRITE;
        wr_done = acc_done & PWRITE & ~st_ff.pslverr;
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        // Receiver terms; the line is sampled on ticks only
        s = RXD;
        fall = ~s & (&st_ff.hist);
        c = st_ff.cnt + 5'h01;
        v = {st_ff.samp[1:0], s};
        bit_val = maj3(v);
        unequal = (v != 3'h0) && (v != 3'h7);
        frame_done = 1'b0;
        new_framing = 1'b0;
        new_noise = 1'b0;
        is_break = 1'b0;
        last_idx = st_ff.ctrl_nine ? LAST_IDX_9 : LAST_IDX_8;
        rx_low = 8'h00;
        rx_ninth = 1'b0;
        clr_flags = 1'b0;
        evt_set = '0;
        evt_clr = '0;
        full_irq = 1'b0;
        evt_irq = 1'b0;

        // Register read mux, answered one cycle into the access phase
        unique case (PADDR)
            OFS_CTRL: begin
                rd_val[CTRL_RX_EN_BIT] = st_ff.ctrl_en;
                rd_val[CTRL_NINE_BIT] = st_ff.ctrl_nine;
                rd_val[CTRL_IRQ_EN_BIT] = st_ff.rx_irq_enable;
            end
            OFS_BAUD: begin
                rd_val[15:0] = st_ff.baud_div;
            end
            OFS_STATUS: begin
                rd_val[STAT_FULL_BIT] = st_ff.rx_full_flag;
                rd_val[STAT_FRAMING_BIT] = st_ff.framing_error_flag;
                rd_val[STAT_NOISE_BIT] = st_ff.noise_flag;
            end
            OFS_DATA_LOW: begin
                rd_val[7:0] = st_ff.data_reg_low;
            end
            OFS_DATA_HIGH: begin
                rd_val[0] = st_ff.ninth_rx_bit;
            end
            OFS_IRQ_STAT: begin
                rd_val[EVT_W-1:0] = st_ff.irq_stat;
            end
            OFS_IRQ_MASK: begin
                rd_val[EVT_W-1:0] = st_ff.irq_mask;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase

        // One wait state: ready follows the first access cycle
        nxt_st.pready = acc_first;
        if (acc_first) begin
            nxt_st.prdata = PWRITE ? 32'h0000_0000 : rd_val;
            nxt_st.pslverr = ~mapped;
        end else if (acc_done) begin
            nxt_st.pslverr = 1'b0;
        end

        // Writes take effect at the completing edge only
        if (wr_done && PSTRB[0]) begin
            unique case (PADDR)
                OFS_CTRL: begin
                    nxt_st.ctrl_en = PWDATA[CTRL_RX_EN_BIT];
                    nxt_st.ctrl_nine = PWDATA[CTRL_NINE_BIT];
                    nxt_st.rx_irq_enable = PWDATA[CTRL_IRQ_EN_BIT];
                end
                OFS_BAUD: begin
                    nxt_st.baud_div[7:0] = PWDATA[7:0];
                end
                OFS_IRQ_STAT: begin
                    evt_clr = PWDATA[EVT_W-1:0];
                end
                OFS_IRQ_MASK: begin
                    nxt_st.irq_mask = PWDATA[EVT_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // Upper divisor byte on lane one
        if (wr_done && PSTRB[1] && PADDR == OFS_BAUD) begin
            nxt_st.baud_div[15:8] = PWDATA[15:8];
        end

        // Two-step flag clear: status read while full, then data low read
        if (rd_done && PADDR == OFS_STATUS && st_ff.rx_full_flag) begin
            nxt_st.clear_armed = 1'b1;
        end
        if (rd_done && PADDR == OFS_DATA_LOW) begin
            clr_flags = st_ff.clear_armed;
            nxt_st.clear_armed = 1'b0;
        end

        // Receiver; disabling aborts a frame but keeps flags
        if (!st_ff.ctrl_en) begin
            // Cleared history needs three high ticks after enable
            nxt_st.phase = PH_IDLE;
            nxt_st.cnt = 5'h00;
            nxt_st.hist = 3'h0;
            nxt_st.frame_noise = 1'b0;
        end else if (tick) begin
            nxt_st.hist = {st_ff.hist[1:0], s};
            nxt_st.cnt = c;
            unique case (st_ff.phase)
                // Hunt for a low sample after three highs
                PH_IDLE: begin
                    nxt_st.cnt = 5'h00;
                    nxt_st.frame_noise = 1'b0;
                    if (fall) begin
                        nxt_st.phase = PH_START;
                        nxt_st.cnt = 5'h01;
                        nxt_st.samp = 3'h0;
                    end
                end

                // Verify at 3, 5, 7; ticks 8 to 10 only report noise
                PH_START: begin
                    if (c == TICK_V1 || c == TICK_V2 || c == TICK_V3 ||
                        (c >= TICK_D1 && c <= TICK_D3)) begin
                        nxt_st.samp = v;
                    end
                    // Two or more highs: false start, silent restart
                    if (c == TICK_V3) begin
                        if (ones3(v) > 2'd1) begin
                            nxt_st.phase = PH_IDLE;
                            nxt_st.cnt = 5'h00;
                        end else if (ones3(v) == 2'd1) begin
                            nxt_st.frame_noise = 1'b1;
                        end
                    end
                    if (c == TICK_D3 && v != 3'h0) begin
                        nxt_st.frame_noise = 1'b1;
                    end
                    if (c == TICK_LAST) begin
                        nxt_st.phase = PH_DATA;
                        nxt_st.cnt = 5'h00;
                        nxt_st.bit_idx = 4'h0;
                        nxt_st.last_one = 1'b0;
                    end
                end

                // Majority of ticks 8, 9, 10 decides each bit
                PH_DATA: begin
                    if (c >= TICK_D1 && c <= TICK_D3) begin
                        nxt_st.samp = v;
                    end
                    if (c == TICK_D3) begin
                        // LSB first, entering at the top
                        nxt_st.shift = {bit_val, st_ff.shift[8:1]};
                        nxt_st.last_one = bit_val;
                        if (unequal) begin
                            nxt_st.frame_noise = 1'b1;
                        end
                    end
                    // Realign on a one-to-zero edge outside the sample window
                    if (fall && st_ff.last_one && (c < TICK_D1 || c > TICK_D3)) begin
                        nxt_st.cnt = 5'h01;
                        nxt_st.last_one = 1'b0;
                        if (c > TICK_D3) begin
                            if (st_ff.bit_idx == last_idx) begin
                                nxt_st.phase = PH_STOP;
                            end else begin
                                nxt_st.bit_idx = st_ff.bit_idx + 4'h1;
                            end
                        end
                    end else if (c == TICK_LAST) begin
                        nxt_st.cnt = 5'h00;
                        if (st_ff.bit_idx == last_idx) begin
                            nxt_st.phase = PH_STOP;
                        end else begin
                            nxt_st.bit_idx = st_ff.bit_idx + 4'h1;
                        end
                    end
                end

                // Stop slot decides framing and ends the frame
                PH_STOP: begin
                    if (c >= TICK_D1 && c <= TICK_D3) begin
                        nxt_st.samp = v;
                    end
                    if (c == TICK_D3) begin
                        frame_done = 1'b1;
                        new_framing = ~bit_val;
                        new_noise = st_ff.frame_noise | unequal;
                        nxt_st.phase = PH_IDLE;
                        nxt_st.cnt = 5'h00;
                        nxt_st.frame_noise = 1'b0;
                    end
                end
                default: begin
                    nxt_st.phase = PH_IDLE;
                end
            endcase
        end

        // Data portion of the shift register, by character length
        if (st_ff.ctrl_nine) begin
            rx_low = st_ff.shift[7:0];
            rx_ninth = st_ff.shift[8];
        end else begin
            rx_low = st_ff.shift[8:1];
            rx_ninth = 1'b0;
        end
        // Break: all-zero data with a low stop slot
        is_break = new_framing && rx_low == 8'h00 && !rx_ninth;

        // Flags collect until the two-step clear
        if (clr_flags) begin
            nxt_st.rx_full_flag = 1'b0;
            nxt_st.framing_error_flag = 1'b0;
            nxt_st.noise_flag = 1'b0;
        end

        // A completing frame wins over a same-cycle clear
        if (frame_done) begin
            nxt_st.data_reg_low = is_break ? 8'h00 : rx_low;
            nxt_st.ninth_rx_bit = is_break ? 1'b0 : rx_ninth;
            nxt_st.rx_full_flag = 1'b1;
            nxt_st.framing_error_flag = nxt_st.framing_error_flag | new_framing;
            nxt_st.noise_flag = nxt_st.noise_flag | new_noise;
            // Any completion drops a pending clear
            nxt_st.clear_armed = 1'b0;
            evt_set[EVT_FRAME_BIT] = 1'b1;
            evt_set[EVT_FRAMING_BIT] = new_framing;
            evt_set[EVT_NOISE_BIT] = new_noise;
        end
        // Set wins over a same-cycle write-one clear
        nxt_st.irq_stat = (st_ff.irq_stat & ~evt_clr) | evt_set;
        // Interrupt level follows the next flag values
        full_irq = nxt_st.rx_full_flag & nxt_st.rx_irq_enable;
        evt_irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
        nxt_st.irq = full_irq | evt_irq;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            // Receiver off, divisor at its default rate
            st_ff <= '0;
            st_ff.phase <= PH_IDLE;
            st_ff.baud_div <= BAUD_DIV_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign PRDATA = st_ff.prdata;
    assign PREADY = st_ff.pready;
    assign PSLVERR = st_ff.pslverr;
    assign IRQ = st_ff.irq;

endmodule // rx_recovery
`default_nettype wire

/* logic/rx_recovery_pkg.sv */
// Shared constants and types for the serial receive data recovery block
package rx_recovery_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BAUD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_DATA_LOW = 8'h0c;
    localparam logic [7:0] OFS_DATA_HIGH = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    // control_reg_two field positions
    localparam int CTRL_RX_EN_BIT = 0;
    localparam int CTRL_NINE_BIT = 1;
    localparam int CTRL_IRQ_EN_BIT = 2;
    // status_reg_one field positions
    localparam int STAT_FULL_BIT = 0;
    localparam int STAT_FRAMING_BIT = 1;
    localparam int STAT_NOISE_BIT = 2;
    // Event register positions (status and mask share the layout)
    localparam int EVT_FRAME_BIT = 0;
    localparam int EVT_FRAMING_BIT = 1;
    localparam int EVT_NOISE_BIT = 2;
    localparam int EVT_W = 3;

    // Timing
    localparam int CLK_FREQ_HZ = 200_000_000;
    localparam int DEFAULT_BAUD = 9600;
    localparam int OVERSAMPLE = 16;
    localparam logic [15:0] BAUD_DIV_RESET = 16'(CLK_FREQ_HZ / (DEFAULT_BAUD * OVERSAMPLE));

    // Oversample tick positions within one bit
    localparam logic [4:0] TICK_V1 = 5'h03;
    localparam logic [4:0] TICK_V2 = 5'h05;
    localparam logic [4:0] TICK_V3 = 5'h07;
    localparam logic [4:0] TICK_D1 = 5'h08;
    localparam logic [4:0] TICK_D3 = 5'h0a;
    localparam logic [4:0] TICK_LAST = 5'h10;

    // Data bit indices of the last data bit
    localparam logic [3:0] LAST_IDX_8 = 4'h7;
    localparam logic [3:0] LAST_IDX_9 = 4'h8;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_START,
        PH_DATA,
        PH_STOP
    } rx_phase_t;

    typedef struct packed {
        logic [15:0] count;
        logic tick;
    } div_state_t;

    typedef struct packed {
        rx_phase_t phase;
        logic [4:0] cnt;
        logic [3:0] bit_idx;
        logic [2:0] hist;
        logic [2:0] samp;
        logic [8:0] shift;
        logic last_one;
        logic frame_noise;
        logic ctrl_en;
        logic ctrl_nine;
        logic rx_irq_enable;
        logic [15:0] baud_div;
        logic [7:0] data_reg_low;
        logic ninth_rx_bit;
        logic rx_full_flag;
        logic framing_error_flag;
        logic noise_flag;
        logic clear_armed;
        logic [EVT_W-1:0] irq_stat;
        logic [EVT_W-1:0] irq_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } rx_state_t;

    function automatic logic maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    function automatic logic [1:0] ones3(input logic [2:0] v);
        return {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
    endfunction

endpackage

/* tb/rx_line_model.sv */
// Remote transmitter model: plays one line sample per clock
`timescale 1ns/1ps
`default_nettype none
module rx_line_model #(
    parameter int N = 256
) (
    input wire logic clk,
    input wire logic go,
    input wire logic [N-1:0] pat,
    output logic txd,
    output logic busy
);
    logic [N-1:0] sh_ff;
    int cnt_ff = 0;
    always_ff @(posedge clk) begin
        if (go) begin
            sh_ff <= pat;
            cnt_ff <= N;
        end else if (cnt_ff > 0) begin
            sh_ff <= sh_ff >> 1;
            cnt_ff <= cnt_ff - 1;
        end
    end
    assign busy = cnt_ff > 0;
    // Line idles high between frames
    assign txd = busy ? sh_ff[0] : 1'b1;
endmodule // rx_line_model
`default_nettype wire

/* tb/rx_recovery_chk.sv */
// Bus handshake and flag checks bound to the receiver top
`timescale 1ns/1ps
`default_nettype none
module rx_recovery_chk
    import rx_recovery_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic RXD,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    wire logic mapped = PADDR[1:0] == 2'h0 && PADDR <= OFS_IRQ_MASK;
    wire logic rd_stat = PREADY && !PWRITE && PADDR == OFS_STATUS;
    a_ready_one_wait: assert property ($rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY)
        else $error("ready not one cycle after access start");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access phase");
    a_err_unmapped: assert property (PREADY && !mapped |-> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (PREADY && mapped |-> !PSLVERR)
        else $error("mapped access refused");
    a_write_zero: assert property (PREADY && PWRITE |-> PRDATA == 32'h0)
        else $error("read data not zero on write");
    a_framing_full: assert property (
        rd_stat && PRDATA[STAT_FRAMING_BIT] |-> PRDATA[STAT_FULL_BIT])
        else $error("framing error without full flag");
    a_noise_full: assert property (
        rd_stat && PRDATA[STAT_NOISE_BIT] |-> PRDATA[STAT_FULL_BIT])
        else $error("noise flag without full flag");
    a_irq_fall_cause: assert property ($fell(IRQ) |-> $past(PREADY))
        else $error("interrupt dropped without bus access");
    c_unmapped: cover property (PREADY && PSLVERR);
    c_irq_rise: cover property ($rose(IRQ));
    c_framing_read: cover property (rd_stat && PRDATA[STAT_FRAMING_BIT]);
endmodule // rx_recovery_chk
bind rx_recovery rx_recovery_chk u_chk (
    .CLK(CLK), .RST_N(RST_N), .RXD(RXD), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ)
);
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the serial receive recovery block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import rx_recovery_pkg::*;
;
    typedef struct {
        logic [8:0] d;
        logic nine;
        logic stp;
        int bt;
        int g;
        logic [2:0] st;
        logic [7:0] lo;
        logic hi;
    } row_t;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic go = 1'b0;
    logic [255:0] pat = '1;
    logic [31:0] PRDATA, v;
    logic PREADY, PSLVERR, IRQ, RXD, busy, e;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    // Glitch index: start tick1 at 12, start tick3 at 14, bit0 tick9 at 36
    row_t rows [12] = '{
        '{9'h0a5, 0, 1, 16, -1, 3'h1, 8'ha5, 0},
        '{9'h13c, 1, 1, 16, -1, 3'h1, 8'h3c, 1},
        '{9'h05a, 0, 0, 16, -1, 3'h3, 8'h5a, 0},
        '{9'h000, 0, 0, 16, -1, 3'h3, 8'h00, 0},
        '{9'h0c3, 0, 1, 16, 36, 3'h5, 8'hc3, 0},
        '{9'h0a5, 0, 1, 16, 14, 3'h5, 8'ha5, 0},
        '{9'h0a5, 0, 1, 16, 20, 3'h5, 8'ha5, 0},
        '{9'h0a5, 0, 1, 16, 164, 3'h5, 8'ha5, 0},
        '{9'h0a5, 0, 1, 16, 4, 3'h1, 8'ha5, 0},
        '{9'h055, 0, 1, 15, -1, 3'h1, 8'h55, 0},
        '{9'h055, 0, 1, 17, -1, 3'h1, 8'h55, 0},
        '{9'h1ff, 1, 0, 16, -1, 3'h3, 8'hff, 1}
    };
    rx_recovery u_rx_recovery (
        .CLK(CLK), .RST_N(RST_N), .RXD(RXD), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hf),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ)
    );
    rx_line_model u_rx_line_model (.clk(CLK), .go(go), .pat(pat), .txd(RXD), .busy(busy));
    always #2.5 CLK = ~CLK;
    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: pin %b expected %b", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK);
        while (PREADY !== 1'b1) @(posedge CLK);
        v = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic play(input logic [255:0] p);
        pat <= p;
        go <= 1'b1;
        @(posedge CLK);
        go <= 1'b0;
        @(posedge CLK);
        while (busy) @(posedge CLK);
    endtask
    // Twelve idle samples, start, data LSB first, stop; bt samples per bit
    function automatic logic [255:0] mk(logic [8:0] d, logic nine, logic stp, int bt, int g);
        logic [255:0] p;
        int n;
        p = '1;
        n = nine ? 9 : 8;
        for (int i = 0; i < bt; i++) begin
            p[12 + i] = 1'b0;
            for (int b = 0; b < n; b++) p[12 + bt * (b + 1) + i] = d[b];
            p[12 + bt * (n + 1) + i] = stp;
        end
        if (g >= 0) p[g] = ~p[g];
        return p;
    endfunction
    function automatic logic [31:0] ctl(input logic nine, input logic ie);
        logic [31:0] c;
        c = 32'h0;
        c[CTRL_RX_EN_BIT] = 1'b1;
        c[CTRL_NINE_BIT] = nine;
        c[CTRL_IRQ_EN_BIT] = ie;
        return c;
    endfunction
    initial begin
        repeat (12) @(posedge CLK);
        RST_N <= 1'b1;
        apb(0, OFS_CTRL, 0);
        chk(v, 32'h0);
        apb(0, OFS_BAUD, 0);
        chk(v, 32'(BAUD_DIV_RESET));
        apb(0, OFS_IRQ_MASK, 0);
        chk(v, 32'h0);
        apb(0, 8'h1c, 0);
        chk(v, 32'h0);
        chk1(e, 1'b1);
        // One oversample tick per clock
        apb(1, OFS_BAUD, 32'h1);
        foreach (rows[i]) begin
            apb(1, OFS_CTRL, ctl(rows[i].nine, 1'b0));
            play(mk(rows[i].d, rows[i].nine, rows[i].stp, rows[i].bt, rows[i].g));
            apb(0, OFS_STATUS, 0);
            chk(v, {29'h0, rows[i].st});
            apb(0, OFS_DATA_LOW, 0);
            chk(v, {24'h0, rows[i].lo});
            apb(0, OFS_DATA_HIGH, 0);
            chk(v, {31'h0, rows[i].hi});
            apb(0, OFS_IRQ_STAT, 0);
            chk(v, {29'h0, rows[i].st});
            apb(1, OFS_IRQ_STAT, 32'h7);
            apb(0, OFS_STATUS, 0);
            chk(v, 32'h0);
        end
        // Data read without a status read first keeps the flag
        apb(1, OFS_CTRL, ctl(0, 0));
        play(mk(9'h0f0, 0, 1, 16, -1));
        apb(0, OFS_DATA_LOW, 0);
        chk(v, 32'h0f0);
        apb(0, OFS_STATUS, 0);
        chk(v, 32'h1);
        apb(0, OFS_DATA_LOW, 0);
        apb(0, OFS_STATUS, 0);
        chk(v, 32'h0);
        apb(1, OFS_IRQ_STAT, 32'h7);
        apb(1, OFS_CTRL, ctl(0, 1));
        play(mk(9'h081, 0, 1, 16, -1));
        chk1(IRQ, 1'b1);
        apb(1, OFS_CTRL, ctl(0, 0));
        repeat (2) @(posedge CLK);
        chk1(IRQ, 1'b0);
        apb(1, OFS_IRQ_MASK, 32'h2);
        apb(0, OFS_IRQ_MASK, 0);
        chk(v, 32'h2);
        chk1(IRQ, 1'b0);
        play(mk(9'h081, 0, 0, 16, -1));
        chk1(IRQ, 1'b1);
        apb(1, OFS_IRQ_STAT, 32'h2);
        repeat (2) @(posedge CLK);
        chk1(IRQ, 1'b0);
        apb(1, OFS_CTRL, ctl(0, 1));
        repeat (2) @(posedge CLK);
        chk1(IRQ, 1'b1);
        // Second reset in mid-run
        RST_N <= 1'b0;
        repeat (3) @(posedge CLK);
        chk1(IRQ, 1'b0);
        RST_N <= 1'b1;
        apb(0, OFS_STATUS, 0);
        chk(v, 32'h0);
        apb(0, OFS_CTRL, 0);
        chk(v, 32'h0);
        conclude();
    end
endmodule // testbench
`default_nettype wire
